// *** hw/mpba_pkg.sv ***
package mpba_pkg;
    // Population of the shared bus
    localparam int NPROC = 8;
    localparam int ID_W = 3;
    // Bus clock and self-refresh settle time before grant
    localparam int CLK_PERIOD_NS = 8;
    localparam int SREF_SETTLE_NS = 24;
    localparam int SREF_SETTLE_CYC_RAW = (SREF_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SREF_SETTLE_CYC = (SREF_SETTLE_CYC_RAW < 1) ? 1 : SREF_SETTLE_CYC_RAW;
    localparam int CNT_W = 4;
    // Width of the bundle passed through the pin synchroniser
    localparam int SYNC_W = NPROC + 7 + ID_W;
    // Bit positions inside that bundle
    localparam int SP_BR = 0;
    localparam int SP_HBR = NPROC;
    localparam int SP_HBG = NPROC + 1;
    localparam int SP_DEADLOCK_BACKOFF = NPROC + 2;
    localparam int SP_CPA = NPROC + 3;
    localparam int SP_DPA = NPROC + 4;
    localparam int SP_MI = NPROC + 5;
    localparam int SP_LOCK = NPROC + 6;
    localparam int SP_ID = NPROC + 7;

    // Hand-over of the bus to the host
    typedef enum logic [1:0] {
        HG_IDLE,
        HG_DRAIN,
        HG_REFRESH,
        HG_GRANT
    } mpba_hg_t;
endpackage

// *** hw/mpba_if.sv ***
`timescale 1ns/1ps
interface mpba_if;
    import mpba_pkg::*;
    // Processor drives: each bit with its own low-active enable, except sdram_self_refresh
    logic [NPROC-1:0] req_o;
    logic [NPROC-1:0] req_oe_n;
    logic grant_o;
    logic grant_oe_n;
    logic mi_o;
    logic mi_oe_n;
    logic lock_o;
    logic lock_oe_n;
    logic cpa_oe_n;
    logic dpa_oe_n;
    logic bus_pins_oe_n;
    logic sdram_self_refresh;
    // Host drives
    logic host_request_n;
    logic deadlock_backoff_n;
    // Testbench drives: peers, pull-ups and strap levels
    logic [NPROC-1:0] peer_others_n;
    logic core_others_n;
    logic dma_others_n;
    logic mi_strap;
    logic lock_strap;
    // Resolved wire levels, pull-up wherever nobody drives, strap level on master indicator and bus lock
    logic [NPROC-1:0] peer_request_lines_n;
    logic host_grant_n;
    logic master_indicator;
    logic bus_locked_flag;
    logic core_priority_line_n;
    logic dma_priority_line_n;

    assign peer_request_lines_n = peer_others_n & (req_oe_n | req_o);
    assign host_grant_n = grant_oe_n | grant_o;
    assign master_indicator = mi_oe_n ? mi_strap : mi_o;
    assign bus_locked_flag = lock_oe_n ? lock_strap : lock_o;
    assign core_priority_line_n = core_others_n & cpa_oe_n;
    assign dma_priority_line_n = dma_others_n & dpa_oe_n;

    modport proc (
        output req_o, req_oe_n, grant_o, grant_oe_n, mi_o, mi_oe_n, lock_o, lock_oe_n,
        output cpa_oe_n, dpa_oe_n, bus_pins_oe_n, sdram_self_refresh,
        input peer_request_lines_n, host_request_n, host_grant_n, deadlock_backoff_n,
        input master_indicator, bus_locked_flag, core_priority_line_n, dma_priority_line_n
    );
    modport host (
        output host_request_n, deadlock_backoff_n,
        input host_grant_n
    );
endinterface

// *** hw/mpba_sync.sv ***
`timescale 1ns/1ps
// Two-stage synchroniser for pin levels; first stage feeds only the second
module mpba_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    // Both stages held in one packed struct
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } mpba_sync_st_t;

    mpba_sync_st_t st_reg;
    mpba_sync_st_t st_next;

    // Shift one stage per edge; no reset so straps are seen during reset
    always_comb begin
        st_next = st_reg;
        st_next.meta = din;
        st_next.stable = st_reg.meta;
    end

    // State register
    always_ff @(posedge clk) begin
        st_reg <= st_next;
    end

    assign dout = st_reg.stable;
endmodule

// *** hw/mpba_host.sv ***
`timescale 1ns/1ps
// Host end: asks for the bus, may force back-off on deadlock
module mpba_host (
    input wire logic clk,
    input wire logic resetn,
    mpba_if.host link,
    input wire logic want_bus,
    input wire logic force_backoff,
    output logic bus_granted
);
    import mpba_pkg::*;

    // Registered pin drives and the seen grant
    typedef struct packed {
        logic req;
        logic deadlock_backoff;
        logic granted;
    } mpba_host_st_t;

    mpba_host_st_t st_reg;
    mpba_host_st_t st_next;
    logic grant_s; // Grant pin after two flops, low active

    mpba_sync #(.W(1)) u_sync (
        .clk(clk),
        .din(link.host_grant_n),
        .dout(grant_s)
    );

    // Request held for the whole tenure; grant seen only while asking
    always_comb begin
        st_next = st_reg;
        if (!resetn) begin
            st_next = '0;
        end else begin
            st_next.req = want_bus;
            // Back-off stands on its own; the host alone judges a deadlock
            st_next.deadlock_backoff = force_backoff;
            st_next.granted = st_reg.req && want_bus && !grant_s;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        st_reg <= st_next;
    end

    assign link.host_request_n = !st_reg.req;
    assign link.deadlock_backoff_n = !st_reg.deadlock_backoff;
    assign bus_granted = st_reg.granted;
endmodule

// *** hw/mpba_proc.sv ***
`timescale 1ns/1ps
module mpba_proc #(
    parameter int SETTLE = mpba_pkg::SREF_SETTLE_CYC
) (
    input wire logic clk,
    input wire logic resetn,
    mpba_if.proc link,
    input wire logic [mpba_pkg::ID_W-1:0] processor_identity,
    input wire logic core_access,
    input wire logic dma_hp_access,
    input wire logic dma_np_access,
    input wire logic lock_req,
    input wire logic xact_busy,
    output logic is_master,
    output logic [mpba_pkg::ID_W-1:0] master_id_seen,
    output logic master_valid,
    output logic xact_abort,
    output logic host_owns_bus,
    output logic strap_master,
    output logic strap_lock
);
    import mpba_pkg::*;

    // Whole state of the arbiter
    typedef struct packed {
        logic run;                 // Out of reset, pins driven
        logic [ID_W-1:0] ident;    // Identity caught in reset
        logic s_mi;                // Strap from master indicator pin
        logic s_lock;              // Strap from bus lock pin
        logic mst_valid;           // Some processor owns the bus
        logic [ID_W-1:0] mst_id;   // Who owns it
        mpba_hg_t hg;              // Host hand-over phase
        logic [CNT_W-1:0] cnt;     // Self-refresh settle count
        logic sref;                // Self-refresh command pulse
        logic br;                  // Own request asserted
        logic gdrv;                // Drive the grant pin
        logic gnt;                 // Grant asserted
        logic drv_bus;             // Bus pins driven
        logic core_priority_line;                 // Core priority pulled
        logic dma_priority_line;                 // DMA priority pulled
        logic lock;                // Bus lock asserted
        logic abort;               // Back-off abort
        logic [1:0] cpa_hist;      // Own core priority drive, delayed
        logic [1:0] dpa_hist;      // Own DMA priority drive, delayed
    } mpba_proc_st_t;

    mpba_proc_st_t st_reg;
    mpba_proc_st_t st_next;
    logic [SYNC_W-1:0] pins_s;     // Every pin after two flops

    // Lowest asserted line wins; bit 0 set means a winner exists
    function automatic logic [ID_W:0] pick_lowest(input logic [NPROC-1:0] reqs);
        logic [ID_W:0] res;
        res = '0;
        for (int i = NPROC - 1; i >= 0; i--) begin
            if (reqs[i]) begin
                res = {i[ID_W-1:0], 1'b1};
            end
        end
        return res;
    endfunction

    // All pins pass two flops before any logic reads them
    mpba_sync #(.W(SYNC_W)) u_sync (
        .clk(clk),
        .din({processor_identity, link.bus_locked_flag, link.master_indicator,
              link.dma_priority_line_n, link.core_priority_line_n,
              link.deadlock_backoff_n, link.host_grant_n, link.host_request_n,
              link.peer_request_lines_n}),
        .dout(pins_s)
    );

    // Next state
    always_comb begin
        logic [NPROC-1:0] reqs;
        logic [ID_W:0] win;
        logic me_master;
        logic want;
        logic cpa_other;
        logic dpa_other;
        logic yield;
        logic backoff;
        logic host_req;
        reqs = ~pins_s[SP_BR +: NPROC];
        win = pick_lowest(reqs);
        me_master = st_reg.mst_valid && (st_reg.mst_id == st_reg.ident);
        want = core_access || dma_hp_access || dma_np_access || lock_req;
        // Own pull still echoing through the flops is not a peer's
        cpa_other = !pins_s[SP_CPA] && (st_reg.cpa_hist == 2'b00) && !st_reg.core_priority_line;
        dpa_other = !pins_s[SP_DPA] && (st_reg.dpa_hist == 2'b00) && !st_reg.dma_priority_line;
        // A locked master never yields to priority lines
        yield = me_master && !lock_req && !core_access &&
                (cpa_other || (dpa_other && !dma_hp_access && dma_np_access));
        backoff = me_master && !pins_s[SP_DEADLOCK_BACKOFF];
        host_req = !pins_s[SP_HBR];
        st_next = st_reg;
        if (!resetn) begin
            st_next = '0;
            // Identity and straps are caught every reset cycle; the last one holds
            st_next.ident = pins_s[SP_ID +: ID_W];
            st_next.s_mi = pins_s[SP_MI];
            st_next.s_lock = pins_s[SP_LOCK];
            st_next.hg = HG_IDLE;
        end else begin
            st_next.run = 1'b1;
            st_next.sref = 1'b0;
            // Identical choice in every processor from the same sampled lines
            if (!(st_reg.mst_valid && reqs[st_reg.mst_id])) begin
                st_next.mst_valid = win[0];
                st_next.mst_id = win[ID_W:1];
            end
            // Host hand-over, driven only by the current master
            unique case (st_reg.hg)
                HG_IDLE: begin
                    if (me_master && host_req) begin
                        st_next.hg = HG_DRAIN;
                    end
                end
                HG_DRAIN: begin
                    if (!host_req) begin
                        st_next.hg = HG_IDLE;
                    end else if (!xact_busy || backoff) begin
                        st_next.hg = HG_REFRESH;
                        st_next.sref = 1'b1;
                        st_next.cnt = CNT_W'(SETTLE - 1);
                    end
                end
                HG_REFRESH: begin
                    // Grant only after the memory had time to enter self-refresh
                    if (st_reg.cnt == '0) begin
                        st_next.hg = HG_GRANT;
                    end else begin
                        st_next.cnt = st_reg.cnt - 1'b1;
                    end
                end
                HG_GRANT: begin
                    if (!host_req) begin
                        st_next.hg = HG_IDLE;
                    end
                end
            endcase
            // Request kept through host tenure so mastership does not move
            st_next.br = (st_reg.hg != HG_IDLE) || (want && !yield && !backoff);
            st_next.gdrv = me_master;
            st_next.gnt = me_master && (st_reg.hg == HG_GRANT);
            st_next.drv_bus = me_master && (st_reg.hg == HG_IDLE) && !backoff && !yield;
            st_next.core_priority_line = core_access;
            st_next.dma_priority_line = dma_hp_access;
            st_next.lock = me_master && lock_req;
            st_next.abort = backoff && xact_busy;
            st_next.cpa_hist = {st_reg.cpa_hist[0], st_reg.core_priority_line};
            st_next.dpa_hist = {st_reg.dpa_hist[0], st_reg.dma_priority_line};
        end
    end

    // State register
    always_ff @(posedge clk) begin
        st_reg <= st_next;
    end

    // Only our own line is ever enabled; others only watched
    genvar g;
    generate
        for (g = 0; g < NPROC; g++) begin : g_req
            assign link.req_oe_n[g] = !(st_reg.run && (st_reg.ident == g));
            assign link.req_o[g] = !st_reg.br;
        end
    endgenerate

    // Pin drives; released through reset so straps can be read
    assign link.grant_oe_n = !(st_reg.run && st_reg.gdrv);
    assign link.grant_o = !st_reg.gnt;
    // Strap pins let go as soon as reset falls, so early reset edges see the strap
    assign link.mi_oe_n = !(resetn && st_reg.run);
    assign link.mi_o = st_reg.gdrv;
    assign link.lock_oe_n = !(resetn && st_reg.run);
    assign link.lock_o = st_reg.lock;
    assign link.cpa_oe_n = !(st_reg.run && st_reg.core_priority_line);
    assign link.dpa_oe_n = !(st_reg.run && st_reg.dma_priority_line);
    assign link.bus_pins_oe_n = !(st_reg.run && st_reg.drv_bus);
    assign link.sdram_self_refresh = st_reg.sref;

    // User-side status
    assign is_master = st_reg.gdrv;
    assign master_id_seen = st_reg.mst_id;
    assign master_valid = st_reg.mst_valid;
    assign xact_abort = st_reg.abort;
    // Slaves learn of host tenure from the grant pin
    assign host_owns_bus = st_reg.run && !pins_s[SP_HBG];
    assign strap_master = st_reg.s_mi;
    assign strap_lock = st_reg.s_lock;
endmodule

// *** tb/mpba_checker.sv ***
`timescale 1ns/1ps
// Watches the wires between the processor end and the host end
module mpba_checker (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [mpba_pkg::NPROC-1:0] req_o,
    input wire logic [mpba_pkg::NPROC-1:0] req_oe_n,
    input wire logic grant_o,
    input wire logic grant_oe_n,
    input wire logic mi_o,
    input wire logic mi_oe_n,
    input wire logic lock_oe_n,
    input wire logic bus_pins_oe_n,
    input wire logic sdram_self_refresh,
    input wire logic host_request_n,
    input wire logic deadlock_backoff_n
);
    import mpba_pkg::*;
    // One domain, so clock and reset are given once
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    a_single_req_line: assert property ($countones(~req_oe_n) <= 1)
        else $error("more than one request line driven");
    a_straps_released: assert property ($rose(resetn) |-> mi_oe_n && lock_oe_n)
        else $error("strap pins driven during reset");
    // Grant falls four edges after the refresh pulse with the default settle count
    a_sref_then_grant: assert property ($fell(grant_o) |-> $past(sdram_self_refresh, 4))
        else $error("grant without prior self-refresh");
    a_float_on_grant: assert property (!grant_oe_n && !grant_o |-> bus_pins_oe_n)
        else $error("bus pins driven while host granted");
    a_float_on_sref: assert property (sdram_self_refresh |-> bus_pins_oe_n)
        else $error("bus pins driven at self-refresh");
    a_grant_held: assert property (!grant_oe_n && !grant_o && !host_request_n |=> !grant_o)
        else $error("grant dropped while host still asks");
    // Two sync edges plus two register edges, no slack at the upper bound
    a_grant_dropped: assert property (!grant_oe_n && !grant_o && host_request_n
        |-> ##[1:4] (grant_o || grant_oe_n))
        else $error("grant kept after request withdrawn");
    a_grant_by_master: assert property (!grant_oe_n |-> !mi_oe_n && mi_o)
        else $error("grant driven by a non-master");
    a_backoff_release: assert property ($fell(deadlock_backoff_n)
        |-> ##[1:5] (bus_pins_oe_n && &(req_oe_n | req_o)))
        else $error("bus not released on back-off");
endmodule

// *** tb/mpba_test.sv ***
`timescale 1ns/1ps
// Processor end and host end facing each other on one link
module mpba_test;
    import mpba_pkg::*;
    logic clk, resetn; // Bench clock and reset
    logic [ID_W-1:0] pid; // Identity pins
    logic core, dhp, dnp, lock, busy, want, deadlock_backoff; // User side levels
    logic is_m, mvalid, abort, hown, smaster, slock, granted; // Observed flags
    logic [ID_W-1:0] mseen; // Master seen by arbitration
    int bad_count, num_checks; // Tallies for the verdict
    mpba_if link();
    mpba_proc u_mpba_proc (.clk(clk), .resetn(resetn), .link(link.proc), .processor_identity(pid),
        .core_access(core), .dma_hp_access(dhp), .dma_np_access(dnp), .lock_req(lock),
        .xact_busy(busy), .is_master(is_m), .master_id_seen(mseen), .master_valid(mvalid),
        .xact_abort(abort), .host_owns_bus(hown), .strap_master(smaster), .strap_lock(slock));
    mpba_host u_mpba_host (.clk(clk), .resetn(resetn), .link(link.host), .want_bus(want),
        .force_backoff(deadlock_backoff), .bus_granted(granted));
    mpba_checker u_mpba_checker (.clk(clk), .resetn(resetn), .req_o(link.req_o),
        .req_oe_n(link.req_oe_n), .grant_o(link.grant_o), .grant_oe_n(link.grant_oe_n),
        .mi_o(link.mi_o), .mi_oe_n(link.mi_oe_n), .lock_oe_n(link.lock_oe_n),
        .bus_pins_oe_n(link.bus_pins_oe_n), .sdram_self_refresh(link.sdram_self_refresh),
        .host_request_n(link.host_request_n), .deadlock_backoff_n(link.deadlock_backoff_n));
    // Free-running bus clock, 8 ns
    initial begin
        clk = 0;
        forever #4 clk = ~clk;
    end
    // Compare and tally
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Verdict and end of run
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Bounded wait on mastership, the pins need a few sync edges
    task automatic wait_master(input logic v);
        for (int i = 0; i < 16 && is_m !== v; i++) @(negedge clk);
    endtask
    // Identity and straps change only while reset is held
    task automatic do_reset(input logic [2:0] id, input logic ms, input logic ls);
        resetn = 0;
        pid = id;
        link.mi_strap = ms;
        link.lock_strap = ls;
        {core, dhp, dnp, lock, busy, want, deadlock_backoff} = '0;
        link.peer_others_n = '1;
        link.core_others_n = 1;
        link.dma_others_n = 1;
        // Three cycles do, as strap pins are released the moment reset falls
        repeat (3) @(negedge clk);
        chk("mi_oe_n in reset", link.mi_oe_n, 1);
        chk("lock_oe_n in reset", link.lock_oe_n, 1);
        resetn = 1;
        @(negedge clk);
        chk("strap_master", smaster, ms);
        chk("strap_lock", slock, ls);
    endtask
    // Every identity code drives only its own line
    task automatic t_identity();
        for (int k = 0; k < NPROC; k++) begin
            do_reset(k[2:0], k[0], k[1]);
            core = 1;
            wait_master(1);
            chk("req_oe_n", link.req_oe_n, ~(8'h01 << k));
            chk("request lines", link.peer_request_lines_n, ~(8'h01 << k));
            chk("master_id_seen", mseen, k[7:0]);
            chk("master_valid", mvalid, 1);
            chk("master_indicator", link.master_indicator, 1);
            chk("core pull", link.cpa_oe_n, 0);
            core = 0;
            wait_master(0);
            chk("line released", link.peer_request_lines_n, 8'hFF);
        end
    endtask
    // Order, incumbency, priority yields and lock refusal
    task automatic t_arbitrate();
        do_reset(3'h3, 0, 0);
        link.peer_others_n = 8'hFD; // Peer one holds the bus first
        core = 1;
        repeat (8) @(negedge clk);
        chk("lower id wins", mseen, 8'h01);
        chk("waits its turn", is_m, 0);
        link.peer_others_n = 8'hFF;
        wait_master(1);
        link.peer_others_n = 8'hDF; // Peer five asks, incumbent kept
        repeat (8) @(negedge clk);
        chk("incumbent kept", is_m, 1);
        core = 0;
        dnp = 1;
        repeat (4) @(negedge clk);
        link.core_others_n = 0;
        wait_master(0);
        chk("yield to core", is_m, 0);
        link.core_others_n = 1;
        link.peer_others_n = 8'hFF;
        lock = 1;
        wait_master(1);
        chk("lock driven", link.bus_locked_flag, 1);
        link.peer_others_n = 8'hDF;
        link.dma_others_n = 0;
        repeat (10) @(negedge clk);
        chk("lock refuses yield", is_m, 1);
        lock = 0;
        wait_master(0);
        chk("yield to dma", is_m, 0);
        link.dma_others_n = 1;
        dhp = 1;
        repeat (3) @(negedge clk);
        chk("dma pull", link.dpa_oe_n, 0);
    endtask
    // Host hand-over: drain, self-refresh, grant, hold, release
    task automatic t_host();
        do_reset(3'h2, 0, 0);
        want = 1;
        repeat (12) @(negedge clk);
        chk("slave leaves grant", link.grant_oe_n, 1);
        want = 0;
        core = 1;
        busy = 1;
        wait_master(1);
        want = 1;
        repeat (8) @(negedge clk);
        chk("no grant while busy", link.host_grant_n, 1);
        busy = 0;
        for (int i = 0; i < 10 && link.sdram_self_refresh !== 1'b1; i++) @(negedge clk);
        chk("self refresh", link.sdram_self_refresh, 1);
        chk("pins float", link.bus_pins_oe_n, 1);
        for (int i = 0; i < 16 && granted !== 1'b1; i++) @(negedge clk);
        chk("host granted", granted, 1);
        chk("grant seen", hown, 1);
        repeat (10) @(negedge clk);
        chk("grant held", link.host_grant_n, 0);
        want = 0;
        // The pin trails the host's own flag by the sync and register edges
        for (int i = 0; i < 16 && link.host_grant_n !== 1'b1; i++) @(negedge clk);
        chk("grant withdrawn", link.host_grant_n, 1);
        chk("host released", granted, 0);
    endtask
    // Back-off while a transfer is outstanding
    task automatic t_backoff();
        do_reset(3'h0, 1, 1);
        core = 1;
        busy = 1;
        wait_master(1);
        deadlock_backoff = 1;
        repeat (6) @(negedge clk);
        chk("abort", abort, 1);
        chk("pins float", link.bus_pins_oe_n, 1);
        chk("request dropped", link.peer_request_lines_n, 8'hFF);
        deadlock_backoff = 0;
    endtask
    // Main sequence; first reset starts at time zero
    initial begin
        t_identity();
        t_arbitrate();
        t_host();
        t_backoff();
        final_report();
    end
    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        final_report();
    end
endmodule
